// >>> design/fpom_pkg.sv
/*
  Package for the floating-point operand move and convert block.
  Assumes one clock domain and an AXI4-Lite register port.
*/
package fpom_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ACC_SEL = 8'h08;
  localparam logic [7:0] OFF_RESULT_HI = 8'h0c;
  localparam logic [7:0] OFF_RESULT_LO = 8'h10;
  localparam logic [7:0] OFF_FCC = 8'h14;
  localparam logic [7:0] OFF_SHIFT = 8'h18;
  // ==========================================================
  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DOUBLE_BIT = 4;
  localparam int CTRL_TRUNC_BIT = 5;
  localparam int CTRL_MEM_BIT = 6;
  localparam int CTRL_GO_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================
  // Number format, accumulators and bus responses
  localparam logic [9:0] EXP_BIAS = 10'h080;
  localparam logic [31:0] LOW_HALF_ZERO = 32'h0000_0000;
  localparam logic [31:0] ROUND_ONE = 32'h0000_0001;
  localparam logic [7:0] EXP_ZERO = 8'h00;
  localparam int NUM_ACC = 7;
  localparam logic [2:0] MEM_ACC = 3'h6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [3:0]
  {
    OP_STORE = 4'h0,
    OP_LOAD_CONVERT_DOUBLE_TO_SINGLE_SEL = 4'h1,
    OP_LOAD_CONVERT_SINGLE_TO_DOUBLE_SEL = 4'h2,
    OP_STORE_CONVERT_DOUBLE_TO_SINGLE_SEL = 4'h3,
    OP_STORE_CONVERT_SINGLE_TO_DOUBLE_SEL = 4'h4,
    OP_CLEAR = 4'h5,
    OP_TEST = 4'h6,
    OP_ABS = 4'h7,
    OP_NEG = 4'h8,
    OP_LOAD_EXP = 4'h9
  } fpom_op_t;

  typedef enum logic [2:0]
  {
    ST_READY = 3'h0,
    ST_FETCH = 3'h1,
    ST_EXEC = 3'h2,
    ST_SEND = 3'h3,
    ST_DONE = 3'h4
  } fpom_state_t;

  typedef struct packed
  {
    logic sign;
    logic [7:0] exp;
    logic [54:0] frac;
  } fpom_num_t;

  typedef struct packed
  {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } fpom_axi_req_t;

  typedef struct packed
  {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } fpom_axi_rsp_t;

  typedef struct packed
  {
    logic request;
    logic [15:0] out_word;
    logic trap_minus_zero;
    logic trap_overflow;
    logic trap_underflow;
  } fpom_cpu_out_t;
endpackage

// >>> design/fpom_core.sv
/*
  Operand move and convert block of a floating-point coprocessor.
  Assumes a host CPU moving 16-bit words by request and strobe, and an
  AXI4-Lite master on the same clock for setup and status.
*/
`timescale 1ns/100ps
`default_nettype none
module fpom_core
  import fpom_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register bus
  input wire fpom_pkg::fpom_axi_req_t axi_req,
  output fpom_pkg::fpom_axi_rsp_t axi_rsp,
  // CPU word link
  input wire logic data_strobe,
  input wire logic [15:0] data_in,
  input wire logic latch_advance,
  output fpom_pkg::fpom_cpu_out_t cpu_out
);
  import fpom_pkg::*;

  typedef struct packed
  {
    fpom_state_t state;
    fpom_axi_rsp_t axi;
    fpom_cpu_out_t cpu;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [31:0] ctrl;
    logic [5:0] acc_sel;
    logic [NUM_ACC*64-1:0] acc;
    logic [2:0] word_count;
    logic [15:0] latch_input;
    logic [3:0] fcc;
    logic [6:0] shift_count;
    logic sign_latch;
    logic [9:0] exp_holding_reg;
    logic [1:0] strobe_sync;
    logic [1:0] advance_sync;
    logic [15:0] data_sync1;
    logic [15:0] data_sync2;
    logic strobe_prev;
    logic advance_prev;
    logic busy;
  } fpom_regs_t;

  fpom_regs_t r;
  fpom_regs_t next_r;

  // ==========================================================
  // Helpers
  function automatic fpom_num_t get_acc(input logic [NUM_ACC*64-1:0] a, input logic [2:0] i);
    get_acc = fpom_num_t'(a[i*64 +: 64]);
  endfunction

  function automatic fpom_num_t to_single(input fpom_num_t n, input logic trunc);
    fpom_num_t o;
    o = n;
    o.frac[31:0] = LOW_HALF_ZERO;
    if (!trunc && n.frac[31])
    begin
      o = fpom_num_t'({n.sign, n.exp, n.frac[54:32], LOW_HALF_ZERO} + {ROUND_ONE, LOW_HALF_ZERO});
    end
    to_single = o;
  endfunction

  function automatic logic [15:0] acc_word(input fpom_num_t n, input logic [2:0] k);
    logic [63:0] w;
    w = n;
    acc_word = w[(3 - k[1:0])*16 +: 16];
  endfunction

  logic strobe_edge;
  logic advance_edge;
  logic [15:0] word_in;
  logic [2:0] src_sel;
  logic [2:0] dst_sel;
  logic mem_mode;
  logic is_double;
  logic [3:0] op_code;
  logic [2:0] need_words;
  logic [7:0] plus_one;
  logic neg_legal;
  logic [9:0] exp_sum;

  always_comb
  begin
    strobe_edge = r.strobe_sync[1] && !r.strobe_prev;
    advance_edge = r.advance_sync[1] && !r.advance_prev;
    word_in = r.data_sync2;
    op_code = r.ctrl[CTRL_OP_LSB +: 4];
    is_double = r.ctrl[CTRL_DOUBLE_BIT];
    mem_mode = r.ctrl[CTRL_MEM_BIT];
    src_sel = mem_mode ? MEM_ACC : r.acc_sel[2:0];
    dst_sel = {1'b0, r.acc_sel[4:3]};
    if (op_code == OP_LOAD_CONVERT_DOUBLE_TO_SINGLE_SEL && mem_mode)
    begin
      need_words = 3'h3;
    end
    else if (op_code == OP_TEST || op_code == OP_LOAD_EXP)
    begin
      need_words = 3'h1;
    end
    else
    begin
      need_words = is_double ? 3'h4 : 3'h2;
    end
    plus_one = word_in[14:7] + 8'h01;
    neg_legal = (plus_one == 8'h00) && (word_in[6:0] != 7'h00);
    exp_sum = {word_in[15], word_in[15], word_in[7:0]} + EXP_BIAS;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    fpom_num_t s;
    fpom_num_t d;
    fpom_num_t m;
    s = '0;
    d = '0;
    m = '0;
    next_r = r;
    next_r.strobe_sync = {r.strobe_sync[0], data_strobe};
    next_r.advance_sync = {r.advance_sync[0], latch_advance};
    next_r.data_sync1 = data_in;
    next_r.data_sync2 = r.data_sync1;
    next_r.strobe_prev = r.strobe_sync[1];
    next_r.advance_prev = r.advance_sync[1];
    next_r.cpu.trap_minus_zero = 1'b0;
    next_r.cpu.trap_overflow = 1'b0;
    next_r.cpu.trap_underflow = 1'b0;
    s = get_acc(r.acc, src_sel);
    d = get_acc(r.acc, dst_sel);
    m = get_acc(r.acc, MEM_ACC);

    // Bus slave, write and read channels
    if (!r.aw_held && axi_req.awvalid)
    begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = axi_req.awaddr;
    end
    if (!r.w_held && axi_req.wvalid)
    begin
      next_r.w_held = 1'b1;
      next_r.w_data = axi_req.wdata;
    end
    next_r.axi.awready = !next_r.aw_held;
    next_r.axi.wready = !next_r.w_held;
    if (r.axi.bvalid && axi_req.bready)
    begin
      next_r.axi.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.axi.bvalid)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.axi.bvalid = 1'b1;
      next_r.axi.bresp = AXI_OKAY;
      next_r.axi.awready = 1'b1;
      next_r.axi.wready = 1'b1;
      case (r.aw_addr)
        OFF_CTRL:
        begin
          if (!r.busy)
          begin
            next_r.ctrl = r.w_data;
            next_r.busy = r.w_data[CTRL_GO_BIT];
          end
        end
        OFF_ACC_SEL: next_r.acc_sel = r.w_data[5:0];
        default: next_r.axi.bresp = AXI_SLVERR;
      endcase
    end
    if (r.axi.rvalid && axi_req.rready)
    begin
      next_r.axi.rvalid = 1'b0;
    end
    next_r.axi.arready = !next_r.axi.rvalid;
    if (r.axi.arready && axi_req.arvalid)
    begin
      next_r.axi.arready = 1'b0;
      next_r.axi.rvalid = 1'b1;
      next_r.axi.rresp = AXI_OKAY;
      case (axi_req.araddr)
        OFF_CTRL: next_r.axi.rdata = r.ctrl;
        OFF_STATUS: next_r.axi.rdata = {27'h0, r.word_count, r.cpu.request, r.busy};
        OFF_ACC_SEL: next_r.axi.rdata = {26'h0, r.acc_sel};
        OFF_RESULT_HI: next_r.axi.rdata = d[63:32];
        OFF_RESULT_LO: next_r.axi.rdata = d[31:0];
        OFF_FCC: next_r.axi.rdata = {28'h0, r.fcc};
        OFF_SHIFT: next_r.axi.rdata = {25'h0, r.shift_count};
        default:
        begin
          next_r.axi.rdata = 32'h0;
          next_r.axi.rresp = AXI_SLVERR;
        end
      endcase
    end

    // Operation sequencer
    case (r.state)
      ST_READY:
      begin
        next_r.acc[MEM_ACC*64 +: 64] = 64'h0;
        next_r.word_count = 3'h0;
        if (r.busy)
        begin
          if (op_code == OP_STORE || (op_code == OP_CLEAR && mem_mode))
          begin
            next_r.state = ST_SEND;
            next_r.cpu.request = 1'b1;
            next_r.cpu.out_word = acc_word(op_code == OP_CLEAR ? fpom_num_t'(64'h0) : s, 3'h0);
            next_r.latch_input = acc_word(op_code == OP_CLEAR ? fpom_num_t'(64'h0) : s, 3'h1);
          end
          else if (mem_mode)
          begin
            next_r.state = ST_FETCH;
            next_r.cpu.request = 1'b1;
          end
          else
          begin
            next_r.state = ST_EXEC;
          end
        end
      end
      ST_FETCH:
      begin
        if (strobe_edge)
        begin
          next_r.acc[MEM_ACC*64 + (3 - r.word_count[1:0])*16 +: 16] = word_in;
          next_r.word_count = r.word_count + 3'h1;
          if (r.word_count == 3'h0)
          begin
            next_r.sign_latch = word_in[15];
            next_r.exp_holding_reg = {2'b00, word_in[14:7]};
            next_r.shift_count = word_in[6:0];
          end
          if (r.word_count + 3'h1 == need_words)
          begin
            next_r.cpu.request = 1'b0;
            next_r.state = ST_EXEC;
          end
        end
      end
      ST_EXEC:
      begin
        next_r.state = ST_DONE;
        case (op_code)
          OP_LOAD_CONVERT_DOUBLE_TO_SINGLE_SEL: next_r.acc[dst_sel*64 +: 64] = to_single(s, r.ctrl[CTRL_TRUNC_BIT]);
          OP_LOAD_CONVERT_SINGLE_TO_DOUBLE_SEL: next_r.acc[dst_sel*64 +: 64] = {s[63:32], LOW_HALF_ZERO};
          OP_STORE_CONVERT_DOUBLE_TO_SINGLE_SEL: next_r.acc[src_sel*64 +: 64] = to_single(d, r.ctrl[CTRL_TRUNC_BIT]);
          OP_STORE_CONVERT_SINGLE_TO_DOUBLE_SEL: next_r.acc[src_sel*64 +: 64] = {d[63:32], LOW_HALF_ZERO};
          OP_CLEAR:
          begin
            next_r.sign_latch = 1'b0;
            next_r.acc[src_sel*64 +: 64] = {1'b0, EXP_ZERO, 55'h0};
          end
          OP_TEST:
          begin
            next_r.fcc = {s.sign, s.exp == EXP_ZERO, 1'b0, 1'b0};
            next_r.cpu.trap_minus_zero = mem_mode && s.sign && s.exp == EXP_ZERO;
          end
          OP_ABS, OP_NEG:
          begin
            m = s;
            m.sign = (op_code == OP_ABS) ? 1'b0 : !s.sign;
            if (s.exp == EXP_ZERO)
            begin
              m = '0;
            end
            next_r.acc[src_sel*64 +: 64] = m;
            if (mem_mode)
            begin
              next_r.state = ST_SEND;
              next_r.word_count = 3'h0;
              next_r.cpu.request = 1'b1;
              next_r.cpu.out_word = acc_word(m, 3'h0);
              next_r.latch_input = acc_word(m, 3'h1);
            end
          end
          OP_LOAD_EXP:
          begin
            if (!word_in[15] && word_in[14:7] == 8'h00 || word_in[15] && neg_legal)
            begin
              next_r.acc[dst_sel*64 + 55 +: 8] = exp_sum[7:0];
            end
            else
            begin
              next_r.cpu.trap_overflow = !word_in[15];
              next_r.cpu.trap_underflow = word_in[15];
            end
          end
          default: next_r.state = ST_DONE;
        endcase
      end
      ST_SEND:
      begin
        if (advance_edge)
        begin
          next_r.word_count = r.word_count + 3'h1;
          next_r.cpu.out_word = r.latch_input;
          next_r.latch_input = acc_word(get_acc(r.acc, src_sel), r.word_count + 3'h2);
          if (r.word_count + 3'h1 == (is_double ? 3'h4 : 3'h2))
          begin
            next_r.cpu.request = 1'b0;
            next_r.state = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        next_r.busy = 1'b0;
        next_r.state = ST_READY;
      end
      default: next_r.state = ST_READY;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      r <= '0;
      r.axi.awready <= 1'b1;
      r.axi.wready <= 1'b1;
      r.axi.arready <= 1'b1;
      r.ctrl <= CTRL_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign axi_rsp = r.axi;
  assign cpu_out = r.cpu;

  // ==========================================================
  // Checks
  property p_ready_clears;
    @(posedge clock) disable iff (reset) r.state == ST_READY |=> r.acc[MEM_ACC*64 +: 64] == 64'h0;
  endproperty
  a_ready_clears: assert property (p_ready_clears) else $error("Memory accumulator not cleared");

  property p_single_store_len;
    @(posedge clock) disable iff (reset) r.state == ST_SEND && !is_double |-> r.word_count < 3'h2;
  endproperty
  a_single_store_len: assert property (p_single_store_len) else $error("Single store too long");

  property p_request_held;
    @(posedge clock) disable iff (reset) (r.state == ST_SEND || r.state == ST_FETCH) && $past(r.state) == r.state |-> r.cpu.request;
  endproperty
  a_request_held: assert property (p_request_held) else $error("Request dropped early");

  property p_test_cv;
    @(posedge clock) disable iff (reset) r.state == ST_EXEC && op_code == OP_TEST |=> r.fcc[1:0] == 2'b00;
  endproperty
  a_test_cv: assert property (p_test_cv) else $error("Test left C or V set");

  logic s_exp_zero_neg;
  assign s_exp_zero_neg = mem_mode && r.acc[src_sel*64 + 63] && r.acc[src_sel*64 + 55 +: 8] == EXP_ZERO;
  property p_minus_zero;
    @(posedge clock) disable iff (reset) r.cpu.trap_minus_zero |-> $past(s_exp_zero_neg);
  endproperty
  a_minus_zero: assert property (p_minus_zero) else $error("Spurious minus zero trap");

  property p_ldexp_bias;
    @(posedge clock) disable iff (reset) r.state == ST_EXEC && op_code == OP_LOAD_EXP && !word_in[15] && word_in[14:7] == 8'h00 |=> r.acc[$past(dst_sel)*64 + 55 +: 8] == {1'b1, $past(word_in[6:0])};
  endproperty
  a_ldexp_bias: assert property (p_ldexp_bias) else $error("Load exponent bias wrong");

  property p_ldexp_trap;
    @(posedge clock) disable iff (reset) r.state == ST_EXEC && op_code == OP_LOAD_EXP && word_in[15] && word_in[14:0] == 15'h7f80 |=> r.cpu.trap_underflow;
  endproperty
  a_ldexp_trap: assert property (p_ldexp_trap) else $error("Special case not trapped");

  property p_shift_count;
    @(posedge clock) disable iff (reset) r.state == ST_FETCH && strobe_edge && r.word_count == 3'h0 |=> r.shift_count == $past(word_in[6:0]);
  endproperty
  a_shift_count: assert property (p_shift_count) else $error("Shift count not loaded");
endmodule
`default_nettype wire

// >>> verification/fpom_cpu_model.sv
/*
  Host CPU model for the operand move and convert block.
  Assumes the bench fills words, sets store_dir and gap, and empties got.
*/
`timescale 1ns/100ps
`default_nettype none
module fpom_cpu_model
(
  // Clock
  input wire logic clock,
  // Block side
  input wire logic request,
  input wire logic [15:0] out_word,
  // CPU side
  output logic data_strobe,
  output logic [15:0] data_in,
  output logic latch_advance
);
  // ====================
  // Word queues and pace
  logic [15:0] words[$];
  logic [15:0] got[$];
  logic store_dir = 1'b0;
  int gap = 0;
  // ====================
  // Word mover
  initial
  begin
    data_strobe = 1'b0;
    latch_advance = 1'b0;
    data_in = 16'h0000;
    forever
    begin
      @(posedge clock);
      if (request === 1'b1 && store_dir)
      begin
        repeat (2) @(posedge clock);
        got.push_back(out_word);
        latch_advance <= 1'b1;
        repeat (3 + gap) @(posedge clock);
        latch_advance <= 1'b0;
        repeat (6 + gap) @(posedge clock);
      end
      else if (request === 1'b1 && words.size() > 0)
      begin
        data_in <= words.pop_front();
        data_strobe <= 1'b1;
        repeat (3 + gap) @(posedge clock);
        data_strobe <= 1'b0;
        data_in <= ~data_in;
        repeat (6 + gap) @(posedge clock);
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/test_fp_operand_move_convert.sv
/*
  Self-checking bench for the operand move and convert block.
  Assumes the design package, the core and the host CPU model.
*/
`timescale 1ns/100ps
`default_nettype none
module test_fp_operand_move_convert;
  import fpom_pkg::*;
  // ====================
  // Signals
  logic clock;
  logic reset;
  fpom_axi_req_t req;
  fpom_axi_rsp_t rsp;
  fpom_cpu_out_t cpu;
  logic data_strobe;
  logic [15:0] data_in;
  logic latch_advance;
  int error_cnt = 0;
  int cmp_count = 0;
  int mz_cnt = 0;
  int ov_cnt = 0;
  int un_cnt = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [63:0] acc;
  // ====================
  // Design, CPU model, clock, trap counters
  fpom_core i_dut (.clock(clock), .reset(reset), .axi_req(req), .axi_rsp(rsp),
    .data_strobe(data_strobe), .data_in(data_in), .latch_advance(latch_advance),
    .cpu_out(cpu));
  fpom_cpu_model i_cpu (.clock(clock), .request(cpu.request), .out_word(cpu.out_word),
    .data_strobe(data_strobe), .data_in(data_in), .latch_advance(latch_advance));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (cpu.trap_minus_zero === 1'b1) mz_cnt <= mz_cnt + 1;
    if (cpu.trap_overflow === 1'b1) ov_cnt <= ov_cnt + 1;
    if (cpu.trap_underflow === 1'b1) un_cnt <= un_cnt + 1;
  end
  // ====================
  // Shared tasks
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic run(input logic [3:0] op, input logic [2:0] fl, input logic [4:0] sel);
    axi_wr(OFF_ACC_SEL, {27'h0, sel});
    axi_wr(OFF_CTRL, {24'h0, 1'b1, fl, op});
    do axi_rd(OFF_STATUS); while (rd[0] !== 1'b0);
  endtask
  task automatic rdacc();
    axi_rd(OFF_RESULT_HI);
    acc[63:32] = rd;
    axi_rd(OFF_RESULT_LO);
    acc[31:0] = rd;
  endtask
  // Memory operand: n words fetched, one spare word must stay unused
  task automatic mem(input logic [79:0] w, input int n, input logic [3:0] op,
    input logic [2:0] fl, input logic [1:0] dst);
    for (int i = 0; i <= n; i++) i_cpu.words.push_back(w[79 - 16 * i -: 16]);
    run(op, fl | 3'h4, {dst, MEM_ACC});
    chk("words left", 64'h1, 64'(i_cpu.words.size()));
    i_cpu.words.delete();
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_regs();
    axi_rd(OFF_CTRL);
    chk("ctrl reset", 64'(CTRL_RESET), 64'(rd));
    axi_rd(OFF_STATUS);
    chk("status reset", 64'h0, 64'(rd));
    axi_rd(8'h40);
    chk("unmapped read", {30'h0, AXI_SLVERR, 32'h0}, {30'h0, resp, rd});
    axi_wr(8'h40, 32'h0000_0001);
    chk("unmapped write", 64'(AXI_SLVERR), 64'(resp));
  endtask
  task automatic t_ldcvt();
    mem({16'h4123, 16'h4567, 16'h9abc, 32'h0}, 2, OP_LOAD_CONVERT_SINGLE_TO_DOUBLE_SEL, 3'h0, 2'h2);
    rdacc();
    chk("single to double", 64'h41234567_00000000, acc);
    i_cpu.gap = 2;
    for (int i = 0; i < 3; i++)
    begin
      mem({16'h4080, 16'hffff, (i == 2) ? 16'h7fff : 16'h8000, 16'h1234, 16'h0}, 3,
        OP_LOAD_CONVERT_DOUBLE_TO_SINGLE_SEL, {1'b0, i == 1, 1'b1}, 2'h1);
      rdacc();
      chk("double to single", {32'h4080ffff + 32'(i == 0), 32'h0}, acc);
    end
    i_cpu.gap = 0;
  endtask
  task automatic t_move();
    logic [63:0] g;
    i_cpu.store_dir = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      i_cpu.got.delete();
      i_cpu.gap = k;
      run((k < 2) ? OP_STORE : OP_CLEAR, {k[1], 1'b0, k[0]}, 5'h12);
      g = 64'h0;
      foreach (i_cpu.got[j]) g = {g[47:0], i_cpu.got[j]};
      chk("word count", 64'(2 + 2 * k[0]), 64'(i_cpu.got.size()));
      chk("moved words", (k < 2 ? 64'h41234567_00000000 : 64'h0) >> (k[0] ? 0 : 32), g);
    end
    i_cpu.store_dir = 1'b0;
    i_cpu.gap = 0;
  endtask
  task automatic t_absneg();
    run(OP_NEG, 3'h0, 5'h12);
    rdacc();
    chk("negate", 64'hc1234567_00000000, acc);
    run(OP_ABS, 3'h0, 5'h12);
    rdacc();
    chk("absolute", 64'h41234567_00000000, acc);
    mem({16'h8012, 16'h3456, 16'h0, 32'h0}, 2, OP_LOAD_CONVERT_SINGLE_TO_DOUBLE_SEL, 3'h0, 2'h1);
    run(OP_NEG, 3'h0, 5'h09);
    rdacc();
    chk("negate zero exp", 64'h0, acc);
  endtask
  task automatic t_test();
    int mz;
    run(OP_TEST, 3'h0, 5'h12);
    axi_rd(OFF_FCC);
    chk("test codes", 64'h0, 64'(rd[3:0]));
    run(OP_CLEAR, 3'h0, 5'h12);
    rdacc();
    chk("register clear", 64'h0, acc);
    run(OP_TEST, 3'h0, 5'h12);
    axi_rd(OFF_FCC);
    chk("test zero", 64'h4, 64'(rd[3:0]));
    for (int i = 0; i < 2; i++)
    begin
      mz = mz_cnt;
      mem({i ? 16'h8080 : 16'h8000, 64'h0}, 1, OP_TEST, 3'h0, 2'h0);
      chk("minus zero trap", 64'(i == 0), 64'(mz_cnt - mz));
    end
  endtask
  task automatic t_ldexp();
    logic [15:0] w[8] = '{16'h0005, 16'h0000, 16'h007f, 16'hffff, 16'hff81, 16'h0080,
      16'hff80, 16'h8080};
    logic [7:0] e;
    int ov;
    int un;
    e = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      ov = ov_cnt;
      un = un_cnt;
      mem({w[i], 64'h0}, 1, OP_LOAD_EXP, 3'h0, 2'h3);
      if (i < 5) e = w[i][7:0] + 8'h80;
      rdacc();
      chk("exponent field", 64'(e), 64'(acc[62:55]));
      axi_rd(OFF_SHIFT);
      chk("shift count", 64'(w[i][6:0]), 64'(rd));
      chk("overflow trap", 64'(i == 5), 64'(ov_cnt - ov));
      chk("underflow trap", 64'(i > 5), 64'(un_cnt - un));
    end
  endtask
  // ====================
  // Main sequence and watchdog
  initial
  begin
    reset = 1'b1;
    req = '0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_regs();
    t_ldcvt();
    t_move();
    t_absneg();
    t_test();
    t_ldexp();
    print_verdict();
  end
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
